/* File: bocb_pkg.sv */
// package for the bit operation and conditional branch execution block
// Notes on behaviour
// - set-bit forces selected bit of addressed RAM nibble to 1, others kept
// - clear-bit forces selected bit of addressed RAM nibble to 0, others kept
// - test-bit copies selected RAM bit into status flag, memory untouched
// - branch with flag 1 copies page buffer to page address, loads PC
// - branch with flag 0 advances PC to next sequence address, sets flag
// - PC successor follows a fixed pseudo-random sequence, not binary increment
// - branch uses flag left by previous instruction; flag holds between instructions
// - branch is short when page buffer equals current page, else long
// - page index register holds 0 to 3, loaded by immediate
// - word index register is 4 bits, 0 to 15, loaded by immediate
package bocb_pkg;
    localparam int PC_W       = 6;
    localparam int PAGE_W     = 4;
    localparam int XIDX_W     = 2;
    localparam int YIDX_W     = 4;
    localparam int NIB_W      = 4;
    localparam int BITSEL_W   = 2;
    localparam logic [PC_W-1:0]   PC_RESET   = 6'h00;
    localparam logic [PAGE_W-1:0] PAGE_RESET = 4'h0;
    localparam logic              FLAG_RESET = 1'b1;
    // feedback taps of the program counter sequence
    localparam logic [PC_W-1:0]   PC_TAPS    = 6'h21;

    typedef enum logic [2:0] {
        BOCB_OP_NONE,
        BOCB_OP_SET_BIT,
        BOCB_OP_CLEAR_BIT,
        BOCB_OP_TEST_BIT,
        BOCB_OP_JUMP,
        BOCB_OP_LOAD_X,
        BOCB_OP_LOAD_Y,
        BOCB_OP_LOAD_PB
    } bocb_op_e;

    typedef struct packed {
        bocb_op_e              op;
        logic [BITSEL_W-1:0]   bitSel;
        logic [PC_W-1:0]       target;
        logic [YIDX_W-1:0]     imm;
    } bocb_instr_s;

    typedef struct packed {
        logic                  we;
        logic [XIDX_W-1:0]     x;
        logic [YIDX_W-1:0]     y;
        logic [NIB_W-1:0]      wdata;
    } bocb_ram_s;
endpackage : bocb_pkg

/* File: bocb_pc_seq.sv */
// pseudo-random successor for the program counter
`timescale 1ns/1ps
module bocb_pc_seq
#(
    parameter int PC_W = bocb_pkg::PC_W
)
(
    input  wire logic [PC_W-1:0] pcCur,
    output logic      [PC_W-1:0] pcNext
);
    logic feedback;

    always_comb
    begin
        // all-ones escape keeps the sequence from locking up
        feedback = ~(^(pcCur & bocb_pkg::PC_TAPS[PC_W-1:0]));
        if (pcCur == {PC_W{1'b1}})
            feedback = 1'b0;
        pcNext = {pcCur[PC_W-2:0], feedback};
    end
endmodule : bocb_pc_seq

/* File: bocb_exec.sv */
// execution of bit operations and conditional branch
`timescale 1ns/1ps
module bocb_exec
#(
    parameter int PC_W   = bocb_pkg::PC_W,
    parameter int PAGE_W = bocb_pkg::PAGE_W
)
(
    input  wire logic                            clk,
    input  wire logic                            rst,
    input  wire logic                            instrValid,
    input  wire bocb_pkg::bocb_instr_s           instr,
    input  wire logic [bocb_pkg::NIB_W-1:0]      ramRdata,
    output bocb_pkg::bocb_ram_s                  ramReq,
    output logic [PC_W-1:0]                      pc_reg,
    output logic [PAGE_W-1:0]                    pageAddr_reg,
    output logic [PAGE_W-1:0]                    pageBuf_reg,
    output logic                                 statusFlag_reg,
    output logic                                 longJump_reg
);
    logic [bocb_pkg::XIDX_W-1:0] xIdx_reg;
    logic [bocb_pkg::YIDX_W-1:0] yIdx_reg;
    logic [PC_W-1:0]             pcSucc;
    logic [bocb_pkg::NIB_W-1:0]  bitMask;
    logic                        selBit;
    logic                        taken;

    bocb_pc_seq #(
        .PC_W   (PC_W)
    ) u_pc_seq (
        .pcCur  (pc_reg),
        .pcNext (pcSucc)
    );

    always_comb
    begin
        bitMask = 4'h1 << instr.bitSel;
        selBit  = ramRdata[instr.bitSel];
        taken   = instrValid && instr.op == bocb_pkg::BOCB_OP_JUMP && statusFlag_reg;
    end

    // read-modify-write of the addressed nibble in the same cycle
    always_comb
    begin
        ramReq.x     = xIdx_reg;
        ramReq.y     = yIdx_reg;
        ramReq.we    = 1'b0;
        ramReq.wdata = ramRdata;
        if (instrValid)
        begin
            unique case (instr.op)
                bocb_pkg::BOCB_OP_SET_BIT:
                begin
                    ramReq.we    = 1'b1;
                    ramReq.wdata = ramRdata | bitMask;
                end
                bocb_pkg::BOCB_OP_CLEAR_BIT:
                begin
                    ramReq.we    = 1'b1;
                    ramReq.wdata = ramRdata & ~bitMask;
                end
                default:
                    ramReq.we    = 1'b0;
            endcase
        end
    end

    // ram index registers
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            xIdx_reg <= '0;
            yIdx_reg <= '0;
        end
        else if (instrValid && instr.op == bocb_pkg::BOCB_OP_LOAD_X)
            xIdx_reg <= instr.imm[bocb_pkg::XIDX_W-1:0];
        else if (instrValid && instr.op == bocb_pkg::BOCB_OP_LOAD_Y)
            yIdx_reg <= instr.imm;
    end

    // status flag, held between instructions
    always_ff @(posedge clk)
    begin
        if (rst)
            statusFlag_reg <= bocb_pkg::FLAG_RESET;
        else if (instrValid)
        begin
            unique case (instr.op)
                bocb_pkg::BOCB_OP_TEST_BIT:  statusFlag_reg <= selBit;
                bocb_pkg::BOCB_OP_JUMP:      statusFlag_reg <= 1'b1;
                default:                     statusFlag_reg <= 1'b1;
            endcase
        end
    end

    // program counter
    always_ff @(posedge clk)
    begin
        if (rst)
            pc_reg <= bocb_pkg::PC_RESET;
        else if (taken)
            pc_reg <= instr.target;
        else if (instrValid)
            pc_reg <= pcSucc;
    end

    // page registers
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            pageAddr_reg <= bocb_pkg::PAGE_RESET;
            pageBuf_reg  <= bocb_pkg::PAGE_RESET;
            longJump_reg <= 1'b0;
        end
        else
        begin
            if (instrValid && instr.op == bocb_pkg::BOCB_OP_LOAD_PB)
                pageBuf_reg <= instr.imm[PAGE_W-1:0];
            if (taken)
            begin
                pageAddr_reg <= pageBuf_reg;
                longJump_reg <= pageBuf_reg != pageAddr_reg;
            end
            else if (instrValid)
                longJump_reg <= 1'b0;
        end
    end
endmodule : bocb_exec

/* File: bocb_monitor.sv */
// assertion checker for the bit operation and branch block
`timescale 1ns/1ps
module bocb_monitor
#(
    parameter int PC_W   = 6,
    parameter int PAGE_W = 4
)
(
    input wire logic                       clk,
    input wire logic                       rst,
    input wire logic                       instrValid,
    input wire bocb_pkg::bocb_instr_s      instr,
    input wire logic [bocb_pkg::NIB_W-1:0] ramRdata,
    input wire bocb_pkg::bocb_ram_s        ramReq,
    input wire logic [PC_W-1:0]            pc_reg,
    input wire logic [PAGE_W-1:0]          pageAddr_reg,
    input wire logic [PAGE_W-1:0]          pageBuf_reg,
    input wire logic                       statusFlag_reg,
    input wire logic                       longJump_reg
);
    logic s, c, t, j;
    assign s = instrValid && instr.op == bocb_pkg::BOCB_OP_SET_BIT;
    assign c = instrValid && instr.op == bocb_pkg::BOCB_OP_CLEAR_BIT;
    assign t = instrValid && instr.op == bocb_pkg::BOCB_OP_TEST_BIT;
    assign j = instrValid && instr.op == bocb_pkg::BOCB_OP_JUMP;
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    property p_set; s |-> ramReq.we && ramReq.wdata == (ramRdata | (4'h1 << instr.bitSel)); endproperty
    a_set: assert property (p_set) else $error("set write wrong");
    property p_clr; c |-> ramReq.we && ramReq.wdata == (ramRdata & ~(4'h1 << instr.bitSel)); endproperty
    a_clr: assert property (p_clr) else $error("clear write wrong");
    property p_tst; t |-> !ramReq.we ##1 statusFlag_reg == $past(ramRdata[instr.bitSel]); endproperty
    a_tst: assert property (p_tst) else $error("test flag wrong");
    property p_jmp; j && statusFlag_reg |=> pc_reg == $past(instr.target)
        && pageAddr_reg == $past(pageBuf_reg); endproperty
    a_jmp: assert property (p_jmp) else $error("taken jump wrong");
    property p_nj; j && !statusFlag_reg |=> statusFlag_reg && pc_reg[5:1] == $past(pc_reg[4:0]); endproperty
    a_nj: assert property (p_nj) else $error("untaken jump wrong");
    property p_lng; j && statusFlag_reg |=> longJump_reg == ($past(pageBuf_reg) != $past(pageAddr_reg)); endproperty
    a_lng: assert property (p_lng) else $error("jump kind wrong");
    property p_hld; !instrValid |-> !ramReq.we ##1 $stable(pc_reg) && $stable(statusFlag_reg); endproperty
    a_hld: assert property (p_hld) else $error("idle changed state");
    property p_flg; s || c |=> statusFlag_reg; endproperty
    a_flg: assert property (p_flg) else $error("flag not set");
endmodule : bocb_monitor

/* File: bocb_ram_model.sv */
// nibble ram answering the execution block
`timescale 1ns/1ps
module bocb_ram_model
(
    input  wire logic                clk,
    input  wire bocb_pkg::bocb_ram_s ramReq,
    output logic [3:0]               ramRdata
);
    logic [3:0] mem [4][16];
    assign ramRdata = mem[ramReq.x][ramReq.y];
    always @(posedge clk)
        if (ramReq.we) mem[ramReq.x][ramReq.y] <= ramReq.wdata;
endmodule : bocb_ram_model

/* File: tb.sv */
// testbench for the bit operation and branch block
`timescale 1ns/1ps
module tb;
    logic                  clk = 0, rst = 1, instrValid = 0;
    bocb_pkg::bocb_instr_s instr = '0;
    bocb_pkg::bocb_ram_s   ramReq;
    logic [3:0]            ramRdata, pa, pb;
    logic [5:0]            pc, ePc;
    logic                  flag, lj;
    int                    bad_count = 0, compares = 0;
    bocb_exec dut (.clk(clk), .rst(rst), .instrValid(instrValid), .instr(instr),
        .ramRdata(ramRdata), .ramReq(ramReq), .pc_reg(pc), .pageAddr_reg(pa),
        .pageBuf_reg(pb), .statusFlag_reg(flag), .longJump_reg(lj));
    bocb_ram_model ram (.clk(clk), .ramReq(ramReq), .ramRdata(ramRdata));
    initial forever #20 clk = ~clk;
    function automatic logic [5:0] succ(input logic [5:0] p);
        return {p[4:0], (&p) ? 1'b0 : ~^(p & bocb_pkg::PC_TAPS)};
    endfunction : succ
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp)
        begin
            bad_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic run(input bocb_pkg::bocb_op_e op, input logic [1:0] b,
                       input logic [5:0] t, input logic [3:0] i);
        @(negedge clk);
        instr = '{op, b, t, i};
        instrValid = 1;
        @(negedge clk);
        instrValid = 0;
    endtask : run
    task automatic t_jump;
        ram.mem[1][7] = 4'h6;
        run(bocb_pkg::BOCB_OP_LOAD_X, 0, 0, 4'h1);
        run(bocb_pkg::BOCB_OP_LOAD_Y, 0, 0, 4'h7);
        run(bocb_pkg::BOCB_OP_TEST_BIT, 0, 0, 0);
        chk(flag, 0);
        run(bocb_pkg::BOCB_OP_JUMP, 0, 6'h2A, 0);
        ePc = 0;
        repeat (4) ePc = succ(ePc);
        chk(pc, ePc);
        chk(flag, 1);
        run(bocb_pkg::BOCB_OP_LOAD_PB, 0, 0, 4'h3);
        run(bocb_pkg::BOCB_OP_JUMP, 0, 6'h15, 0);
        chk({pa, 3'h0, lj}, 8'h31);
        chk(pb, 4'h3);
        chk(pc, 6'h15);
        run(bocb_pkg::BOCB_OP_JUMP, 0, 6'h0C, 0);
        chk({pa, lj, 3'h0}, 8'h30);
        chk(pc, 6'h0C);
    endtask : t_jump
    task automatic t_bits;
        run(bocb_pkg::BOCB_OP_SET_BIT, 2'h3, 0, 0);
        chk(ram.mem[1][7], 4'hE);
        run(bocb_pkg::BOCB_OP_TEST_BIT, 2'h0, 0, 0);
        run(bocb_pkg::BOCB_OP_CLEAR_BIT, 2'h1, 0, 0);
        chk({ram.mem[1][7], 3'h0, flag}, 8'hC1);
        run(bocb_pkg::BOCB_OP_TEST_BIT, 2'h2, 0, 0);
        chk(flag, 1);
        run(bocb_pkg::BOCB_OP_TEST_BIT, 2'h1, 0, 0);
        chk({ram.mem[1][7], 3'h0, flag}, 8'hC0);
    endtask : t_bits
    task automatic conclude;
        $display("mismatches %0d of %0d compares", bad_count, compares);
        if (bad_count == 0 && compares > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : conclude
    initial
    begin
        repeat (20) @(negedge clk);
        rst = 0;
        t_jump();
        t_bits();
        conclude();
    end
    initial
    begin
        #100000;
        bad_count++;
        conclude();
    end
endmodule : tb
bind bocb_exec bocb_monitor #(.PC_W(PC_W), .PAGE_W(PAGE_W)) mon (.clk(clk), .rst(rst),
    .instrValid(instrValid), .instr(instr), .ramRdata(ramRdata), .ramReq(ramReq),
    .pc_reg(pc_reg), .pageAddr_reg(pageAddr_reg), .pageBuf_reg(pageBuf_reg),
    .statusFlag_reg(statusFlag_reg), .longJump_reg(longJump_reg));
